// ==== core/cic_params.svh ====
// constants for the cutter input command block
`ifndef CIC_PARAMS_SVH
`define CIC_PARAMS_SVH
`define CIC_NCMD 10
`define CIC_NPHYS 16
`define CIC_SEL_W 4
`define CIC_SPD_W 16
`define CIC_LEN_W 32
`define CIC_CMD_EN 0
`define CIC_CMD_RUN 1
`define CIC_CMD_VSEL 2
`define CIC_CMD_VRUN 3
`define CIC_CMD_JOGF 4
`define CIC_CMD_JOGR 5
`define CIC_CMD_HOME 6
`define CIC_CMD_CLR 7
`define CIC_CMD_ICUT 8
`define CIC_CMD_TEST 9
`define CIC_MAP_VALID 4
`define CIC_A_RS 8'h00
`define CIC_A_CAN 8'h04
`define CIC_A_JOG 8'h08
`define CIC_A_TRIM 8'h0c
`define CIC_A_HOME 8'h10
`define CIC_A_VSPD 8'h14
`define CIC_A_VRAMP 8'h18
`define CIC_A_LEN 8'h1c
`define CIC_A_TLEN 8'h20
`define CIC_A_STAT 8'h24
`define CIC_A_VFRQ 8'h28
`define CIC_A_MAP 8'h40
`define CIC_A_MAP_END 8'h64
`define CIC_RST_SPD 16'h0000
`define CIC_RST_LEN 32'h0000_0000
`define CIC_RST_RAMP 16'h0001
`endif

// ==== core/cic_pkg.sv ====
// types for the cutter input command block
`include "cic_params.svh"
package cic_pkg;
  typedef enum logic [2:0] {
    ST_OFF, ST_HOLD, ST_JOG, ST_SEEK, ST_HOMEMOVE, ST_AUTO
  } cic_mode_t;
  typedef struct packed {
    logic enable;
    logic counters_rst;
    logic analog_zero;
    logic hold_pos;
    logic auto_cut;
    logic master_virtual;
    logic line_enc_en;
    logic err_clear;
    logic imm_cut;
    logic len_trial;
    logic signed [`CIC_SPD_W-1:0] move_speed;
    logic signed [`CIC_SPD_W-1:0] trim_speed;
    logic [`CIC_SPD_W-1:0] vm_freq;
    logic [`CIC_LEN_W-1:0] cut_len;
  } cic_ctrl_t;
  typedef struct packed {
    logic [`CIC_NPHYS-1:0] s1;
    logic [`CIC_NPHYS-1:0] s2;
    logic [`CIC_NPHYS-1:0] s3;
    logic [`CIC_NPHYS-1:0] phys;
    logic [2:0] cp_sync;
    logic cp_f;
    logic cp_prev;
    logic [`CIC_NCMD-1:0] rs;
    logic [`CIC_NCMD-1:0] can;
    logic [`CIC_NCMD-1:0][`CIC_MAP_VALID:0] map;
    logic [`CIC_SPD_W-1:0] jog_spd;
    logic [`CIC_SPD_W-1:0] trim_spd;
    logic [`CIC_SPD_W-1:0] home_spd;
    logic [`CIC_SPD_W-1:0] vm_spd;
    logic [`CIC_SPD_W-1:0] vm_step;
    logic [`CIC_LEN_W-1:0] len;
    logic [`CIC_LEN_W-1:0] tlen;
    logic [`CIC_NCMD-1:0] cmd_prev;
    logic trial_pend;
    cic_mode_t mode;
    cic_ctrl_t ctrl;
    logic [31:0] prdata;
    logic pslverr;
  } cic_state_t;
endpackage

// ==== core/cic_top.sv ====
// command resolution and mode control for a rotating cutter controller
// Notes on behaviour
// - each command may be mapped to any one of sixteen physical inputs
// - a command is active when its input, serial bit or CAN bit is active
// - serial and CAN bits activate a command even when it is unmapped
// - enable off: functions off except fault acknowledge, master select and trial select, analogue outputs zero, counters held in reset
// - run off: roll held in position; jog and on-demand cut still allowed
// - run on: automatic cutting by length or printmark
// - master select off: line encoder channel is the master axis
// - master select on: frequency generator is master, encoder ignored
// - master select change accepted only while run is off
// - generator run falling: ramp frequency down to 0 Hz and stay stopped
// - generator run rising: ramp frequency up to the selected speed
// - run off: forward or reverse move drives roll at jog speed
// - when manual move ends, hold roll at new position
// - run on: forward or reverse move trims cut position at trim speed
// - homing edge: move forward to cutting pulse, then on to home
// - fault acknowledge edge resets errors and clears messages
// - on-demand cut edge at standstill starts one cut at once
// - after an on-demand cut the next piece has preset length again
// - trial select off cuts normal length, on cuts trial length
// - short trial pulse gives exactly one trial cut at next cycle
// - home position lies opposite the centre of the synchronous zone
// - homing search moves at a configurable speed until the cutting pulse
`timescale 1ns/100ps
`include "cic_params.svh"
module cic_top (
  input wire logic clock, // 40 MHz control clock
  input wire logic arst_n, // asynchronous reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic [`CIC_NPHYS-1:0] control_input_terminal, // field inputs
  input wire logic cut_pulse, // once-per-revolution sensor
  input wire logic roll_standstill, // from roll speed logic
  input wire logic at_home, // from roll position logic
  input wire logic cycle_done, // one pulse per finished cut
  output cic_pkg::cic_ctrl_t ctrl // resolved control outputs
);
  cic_pkg::cic_state_t q;
  cic_pkg::cic_state_t d;
  logic [`CIC_NCMD-1:0] cmd;
  logic [`CIC_NCMD-1:0] rise;
  logic setup;
  logic access;
  logic [31:0] rdat;
  logic rerr;

  function automatic logic [`CIC_SPD_W-1:0] ramp(input logic [`CIC_SPD_W-1:0] cur,
      input logic [`CIC_SPD_W-1:0] tgt, input logic [`CIC_SPD_W-1:0] stp);
    logic [`CIC_SPD_W:0] sum;
    sum = {1'b0, cur} + {1'b0, stp};
    if (cur < tgt) begin
      ramp = (sum > {1'b0, tgt}) ? tgt : sum[`CIC_SPD_W-1:0];
    end else if (cur - tgt > stp) begin
      ramp = cur - stp;
    end else begin
      ramp = tgt;
    end
  endfunction

  function automatic logic map_hit(input logic [7:0] a);
    map_hit = (a >= `CIC_A_MAP) && (a <= `CIC_A_MAP_END) && (a[1:0] == 2'b00);
  endfunction

  // source combination for each command
  for (genvar i = 0; i < `CIC_NCMD; i++) begin : g_cmd
    logic from_pin;
    assign from_pin = q.map[i][`CIC_MAP_VALID] & q.phys[q.map[i][`CIC_SEL_W-1:0]];
    assign cmd[i] = from_pin | q.rs[i] | q.can[i];
  end
  assign rise = cmd & ~q.cmd_prev;

  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign pready = 1'b1;
  assign prdata = q.prdata;
  assign pslverr = q.pslverr;
  assign ctrl = q.ctrl;

  // read data is captured in the setup cycle so that zero-wait access returns a flop
  always_comb begin
    rdat = 32'h0000_0000;
    rerr = 1'b0;
    if (paddr == `CIC_A_RS) begin
      rdat[`CIC_NCMD-1:0] = q.rs;
    end else if (paddr == `CIC_A_CAN) begin
      rdat[`CIC_NCMD-1:0] = q.can;
    end else if (paddr == `CIC_A_JOG) begin
      rdat[`CIC_SPD_W-1:0] = q.jog_spd;
    end else if (paddr == `CIC_A_TRIM) begin
      rdat[`CIC_SPD_W-1:0] = q.trim_spd;
    end else if (paddr == `CIC_A_HOME) begin
      rdat[`CIC_SPD_W-1:0] = q.home_spd;
    end else if (paddr == `CIC_A_VSPD) begin
      rdat[`CIC_SPD_W-1:0] = q.vm_spd;
    end else if (paddr == `CIC_A_VRAMP) begin
      rdat[`CIC_SPD_W-1:0] = q.vm_step;
    end else if (paddr == `CIC_A_LEN) begin
      rdat = q.len;
    end else if (paddr == `CIC_A_TLEN) begin
      rdat = q.tlen;
    end else if (paddr == `CIC_A_STAT) begin
      rdat[`CIC_NCMD-1:0] = cmd;
      rdat[18:16] = q.mode;
      rdat[19] = q.trial_pend;
      rdat[20] = q.ctrl.master_virtual;
    end else if (paddr == `CIC_A_VFRQ) begin
      rdat[`CIC_SPD_W-1:0] = q.ctrl.vm_freq;
    end else if (map_hit(paddr)) begin
      rdat[`CIC_MAP_VALID:0] = q.map[4'((paddr - `CIC_A_MAP) >> 2)];
    end else begin
      rerr = 1'b1;
    end
  end

  always_comb begin
    logic jog;
    logic jog_dir_rev;
    logic en;
    logic run;
    d = q;
    en = cmd[`CIC_CMD_EN];
    run = cmd[`CIC_CMD_RUN] & en;
    jog = en & (cmd[`CIC_CMD_JOGF] ^ cmd[`CIC_CMD_JOGR]);
    jog_dir_rev = cmd[`CIC_CMD_JOGR];
    // pin filter: a change counts once the last two stages agree
    d.s1 = control_input_terminal;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int k = 0; k < `CIC_NPHYS; k++) begin
      if (q.s2[k] == q.s3[k]) begin
        d.phys[k] = q.s3[k];
      end
    end
    d.cp_sync = {q.cp_sync[1:0], cut_pulse};
    if (q.cp_sync[1] == q.cp_sync[2]) begin
      d.cp_f = q.cp_sync[2];
    end
    d.cp_prev = q.cp_f;
    d.cmd_prev = cmd;

    // bus
    if (setup) begin
      d.prdata = pwrite ? 32'h0000_0000 : rdat;
      d.pslverr = rerr;
    end
    if (access & pwrite & ~rerr) begin
      if (paddr == `CIC_A_RS) begin
        d.rs = pwdata[`CIC_NCMD-1:0];
      end else if (paddr == `CIC_A_CAN) begin
        d.can = pwdata[`CIC_NCMD-1:0];
      end else if (paddr == `CIC_A_JOG) begin
        d.jog_spd = pwdata[`CIC_SPD_W-1:0];
      end else if (paddr == `CIC_A_TRIM) begin
        d.trim_spd = pwdata[`CIC_SPD_W-1:0];
      end else if (paddr == `CIC_A_HOME) begin
        d.home_spd = pwdata[`CIC_SPD_W-1:0];
      end else if (paddr == `CIC_A_VSPD) begin
        d.vm_spd = pwdata[`CIC_SPD_W-1:0];
      end else if (paddr == `CIC_A_VRAMP) begin
        d.vm_step = pwdata[`CIC_SPD_W-1:0];
      end else if (paddr == `CIC_A_LEN) begin
        d.len = pwdata;
      end else if (paddr == `CIC_A_TLEN) begin
        d.tlen = pwdata;
      end else if (map_hit(paddr)) begin
        d.map[4'((paddr - `CIC_A_MAP) >> 2)] = pwdata[`CIC_MAP_VALID:0];
      end
    end

    // mode sequencing
    case (q.mode)
      cic_pkg::ST_OFF: begin
        if (en) begin
          d.mode = cic_pkg::ST_HOLD;
        end
      end
      cic_pkg::ST_HOLD: begin
        if (run) begin
          d.mode = cic_pkg::ST_AUTO;
        end else if (rise[`CIC_CMD_HOME]) begin
          d.mode = cic_pkg::ST_SEEK;
        end else if (jog) begin
          d.mode = cic_pkg::ST_JOG;
        end
      end
      cic_pkg::ST_JOG: begin
        if (run) begin
          d.mode = cic_pkg::ST_AUTO;
        end else if (!jog) begin
          d.mode = cic_pkg::ST_HOLD;
        end
      end
      cic_pkg::ST_SEEK: begin
        if (run) begin
          d.mode = cic_pkg::ST_AUTO;
        end else if (q.cp_f & ~q.cp_prev) begin
          d.mode = cic_pkg::ST_HOMEMOVE;
        end
      end
      cic_pkg::ST_HOMEMOVE: begin
        if (run) begin
          d.mode = cic_pkg::ST_AUTO;
        end else if (at_home) begin
          d.mode = cic_pkg::ST_HOLD;
        end
      end
      cic_pkg::ST_AUTO: begin
        if (!run) begin
          d.mode = cic_pkg::ST_HOLD;
        end
      end
      default: begin
        d.mode = cic_pkg::ST_OFF;
      end
    endcase
    if (!en) begin
      d.mode = cic_pkg::ST_OFF;
    end

    // outputs, registered
    d.ctrl.enable = en;
    d.ctrl.counters_rst = ~en;
    d.ctrl.analog_zero = ~en;
    d.ctrl.hold_pos = (d.mode == cic_pkg::ST_HOLD);
    d.ctrl.auto_cut = (d.mode == cic_pkg::ST_AUTO);
    if (!cmd[`CIC_CMD_RUN]) begin
      d.ctrl.master_virtual = cmd[`CIC_CMD_VSEL];
    end
    d.ctrl.line_enc_en = en & ~d.ctrl.master_virtual;
    d.ctrl.move_speed = '0;
    if (d.mode == cic_pkg::ST_JOG) begin
      d.ctrl.move_speed = jog_dir_rev ? -$signed(q.jog_spd) : $signed(q.jog_spd);
    end else if (d.mode == cic_pkg::ST_SEEK || d.mode == cic_pkg::ST_HOMEMOVE) begin
      d.ctrl.move_speed = $signed(q.home_spd);
    end
    d.ctrl.trim_speed = '0;
    if (d.mode == cic_pkg::ST_AUTO && jog) begin
      d.ctrl.trim_speed = jog_dir_rev ? -$signed(q.trim_spd) : $signed(q.trim_spd);
    end
    // generator ramps toward its target at the configured step per clock
    if (!en) begin
      d.ctrl.vm_freq = '0;
    end else begin
      d.ctrl.vm_freq = ramp(q.ctrl.vm_freq, cmd[`CIC_CMD_VRUN] ? q.vm_spd : `CIC_RST_SPD, q.vm_step);
    end
    d.ctrl.err_clear = rise[`CIC_CMD_CLR];
    d.ctrl.imm_cut = rise[`CIC_CMD_ICUT] & en & roll_standstill;
    // a trial request arriving with the cycle end is kept for the next cycle
    d.trial_pend = (rise[`CIC_CMD_TEST] & en) | (q.trial_pend & ~cycle_done);
    d.ctrl.len_trial = cmd[`CIC_CMD_TEST] | d.trial_pend;
    d.ctrl.cut_len = d.ctrl.len_trial ? q.tlen : q.len;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
      q.vm_step <= `CIC_RST_RAMP;
      q.len <= `CIC_RST_LEN;
      q.tlen <= `CIC_RST_LEN;
      q.mode <= cic_pkg::ST_OFF;
      q.ctrl.counters_rst <= 1'b1;
      q.ctrl.analog_zero <= 1'b1;
    end else begin
      q <= d;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  chk_disable_zeroes: assert property (!cmd[`CIC_CMD_EN] |=> q.ctrl.analog_zero && q.ctrl.vm_freq == '0
    && q.ctrl.move_speed == '0) else $error("disabled but outputs not zero");
  chk_disable_ignores: assert property (!cmd[`CIC_CMD_EN] |=> !q.ctrl.auto_cut && !q.ctrl.imm_cut)
    else $error("command acted while disabled");
  chk_run_to_auto: assert property (q.mode == cic_pkg::ST_HOLD && cmd[`CIC_CMD_RUN] && cmd[`CIC_CMD_EN]
    |=> q.ctrl.auto_cut) else $error("run did not start auto cutting");
  chk_master_frozen: assert property (cmd[`CIC_CMD_RUN] |=> $stable(q.ctrl.master_virtual))
    else $error("master select changed while running");
  chk_encoder_ignored: assert property (q.ctrl.master_virtual |-> !q.ctrl.line_enc_en)
    else $error("encoder used with virtual master");
  chk_ramp_down: assert property (!cmd[`CIC_CMD_VRUN] && q.ctrl.vm_freq != '0 && q.vm_step != '0
    |=> q.ctrl.vm_freq < $past(q.ctrl.vm_freq)) else $error("generator not ramping down");
  chk_jog_speed: assert property (q.mode == cic_pkg::ST_JOG && !cmd[`CIC_CMD_JOGR]
    && d.mode == cic_pkg::ST_JOG |=> q.ctrl.move_speed == $signed($past(q.jog_spd)))
    else $error("jog speed wrong");
  chk_jog_end_hold: assert property (q.mode == cic_pkg::ST_JOG && !cmd[`CIC_CMD_RUN]
    && !(cmd[`CIC_CMD_JOGF] ^ cmd[`CIC_CMD_JOGR]) && cmd[`CIC_CMD_EN] |=> q.ctrl.hold_pos)
    else $error("jog end without hold");
  chk_home_seek: assert property (q.mode == cic_pkg::ST_HOLD && rise[`CIC_CMD_HOME] && cmd[`CIC_CMD_EN]
    && !cmd[`CIC_CMD_RUN] |=> q.mode == cic_pkg::ST_SEEK ##0 q.ctrl.move_speed == $signed(q.home_spd))
    else $error("homing did not start");
  chk_clear_pulse: assert property (rise[`CIC_CMD_CLR] |=> q.ctrl.err_clear ##1 !q.ctrl.err_clear
    || rise[`CIC_CMD_CLR]) else $error("error clear not one pulse");
  chk_trial_once: assert property (q.trial_pend && cycle_done && !rise[`CIC_CMD_TEST]
    |=> !q.trial_pend) else $error("trial cut not retired");
  chk_trial_length: assert property (q.ctrl.len_trial |-> q.ctrl.cut_len == $past(q.tlen))
    else $error("trial length not selected");
endmodule

// ==== sim/cic_field_model.sv ====
// field-side model: switch inputs, roll position sensors and cut cycle feedback
`timescale 1ns/100ps
`include "cic_params.svh"
module cic_field_model (
  input wire logic clock, // control clock
  input wire logic arst_n, // reset, active low
  input wire cic_pkg::cic_ctrl_t ctrl, // controller outputs
  input wire logic [`CIC_NPHYS-1:0] pins_req, // switch levels set by the bench
  output logic [`CIC_NPHYS-1:0] control_input_terminal, // field inputs
  output logic cut_pulse, // once per revolution
  output logic at_home, // roll at home position
  output logic roll_standstill, // roll not moving
  output logic cycle_done // end of each automatic cut
);
  logic [6:0] pos_q;
  logic [3:0] cyc_q;
  assign control_input_terminal = pins_req;
  // pulse window lies before home so a search from zero meets it first
  assign cut_pulse = (pos_q >= 7'd40) && (pos_q <= 7'd43);
  // the roll coasts one step past home while the stop takes effect, so home is a region
  assign at_home = (pos_q >= 7'd60);
  assign roll_standstill = (ctrl.move_speed == 16'h0000) && !ctrl.auto_cut;
  assign cycle_done = ctrl.auto_cut && (cyc_q == 4'hf);
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pos_q <= 7'h00;
      cyc_q <= 4'h0;
    end else begin
      if ($signed(ctrl.move_speed) > 0) pos_q <= pos_q + 7'h01;
      else if ($signed(ctrl.move_speed) < 0) pos_q <= pos_q - 7'h01;
      cyc_q <= ctrl.auto_cut ? cyc_q + 4'h1 : 4'h0;
    end
  end
endmodule

// ==== sim/test_cutter_input_command_logic.sv ====
// self-checking bench for the cutter command block
`timescale 1ns/100ps
`include "cic_params.svh"
module test_cutter_input_command_logic;
  logic clock, arst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] pins_req;
  wire logic [15:0] control_input_terminal;
  logic cut_pulse, at_home, roll_standstill, cycle_done;
  cic_pkg::cic_ctrl_t ctrl;
  logic [9:0] rs;
  int failures, samples_checked, cycles, clr_n, cut_n, n;
  cic_top uut (.clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .control_input_terminal(control_input_terminal), .cut_pulse(cut_pulse),
    .roll_standstill(roll_standstill), .at_home(at_home), .cycle_done(cycle_done), .ctrl(ctrl));
  cic_field_model field (.clock(clock), .arst_n(arst_n), .ctrl(ctrl), .pins_req(pins_req),
    .control_input_terminal(control_input_terminal), .cut_pulse(cut_pulse), .at_home(at_home),
    .roll_standstill(roll_standstill), .cycle_done(cycle_done));
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task end_sim;
    $display("checks %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // budget is over twenty times the expected run length
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (ctrl.err_clear === 1'b1) clr_n <= clr_n + 1;
    if (ctrl.imm_cut === 1'b1) cut_n <= cut_n + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      $display("unexpected at %0t: run too long", $time);
      end_sim;
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task cmd(input int i, input logic v);
    rs[i] = v;
    apb(1'b1, `CIC_A_RS, {22'h0, rs});
  endtask
  task settle(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  task pin(input logic [15:0] v);
    @(posedge clock);
    pins_req <= v;
    settle(8);
  endtask
  initial begin
    arst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    pins_req = 16'h0; rs = 10'h0; failures = 0; samples_checked = 0; cycles = 0; clr_n = 0; cut_n = 0;
    repeat (12) @(posedge clock);
    arst_n <= 1'b1;
    settle(1);
    check(ctrl.enable, 1'b0);
    check({ctrl.counters_rst, ctrl.analog_zero}, 2'b11);
    apb(1'b0, `CIC_A_VRAMP, 32'h0);
    check(rd, `CIC_RST_RAMP);
    apb(1'b0, 8'h30, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    apb(1'b1, `CIC_A_JOG, 32'h100);
    apb(1'b1, `CIC_A_TRIM, 32'h40);
    apb(1'b1, `CIC_A_HOME, 32'h20);
    apb(1'b1, `CIC_A_VSPD, 32'h10);
    apb(1'b1, `CIC_A_VRAMP, 32'h4);
    apb(1'b1, `CIC_A_LEN, 32'h1000);
    apb(1'b1, `CIC_A_TLEN, 32'h200);
    $display("test reset and registers done");
    cmd(1, 1'b1); cmd(4, 1'b1); cmd(6, 1'b1); cmd(8, 1'b1);
    settle(2);
    check({ctrl.auto_cut, ctrl.move_speed}, 17'h0);
    check(cut_n, 0);
    check(ctrl.counters_rst, 1'b1);
    rs = 10'h0;
    cmd(0, 1'b1);
    settle(2);
    check({ctrl.enable, ctrl.analog_zero, ctrl.counters_rst}, 3'b100);
    cmd(0, 1'b0);
    apb(1'b1, `CIC_A_CAN, 32'h1);
    settle(2);
    check(ctrl.enable, 1'b1);
    apb(1'b1, `CIC_A_CAN, 32'h0);
    settle(2);
    check(ctrl.enable, 1'b0);
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, `CIC_A_MAP, 32'h10 | i);
      pin(16'h1 << (i ^ 1));
      check(ctrl.enable, 1'b0);
      pin(16'h1 << i);
      check(ctrl.enable, 1'b1);
      pin(16'h0);
    end
    apb(1'b1, `CIC_A_MAP, 32'h0);
    $display("test command sources done");
    // operator homes the roll after enabling and before run
    cmd(0, 1'b1);
    cmd(6, 1'b1);
    settle(2);
    check({16'h0, ctrl.move_speed}, 16'h0020);
    apb(1'b0, `CIC_A_STAT, 32'h0);
    check(rd[18:16], cic_pkg::ST_SEEK);
    n = 0;
    while (!(ctrl.hold_pos === 1'b1) && n < 200) begin
      settle(1);
      n = n + 1;
    end
    check({at_home, ctrl.move_speed}, 17'h10000);
    cmd(6, 1'b0);
    cmd(4, 1'b1);
    settle(2);
    check({ctrl.hold_pos, ctrl.move_speed}, 17'h00100);
    cmd(4, 1'b0);
    settle(2);
    check({ctrl.hold_pos, ctrl.move_speed}, 17'h10000);
    cmd(5, 1'b1);
    settle(2);
    check({16'h0, ctrl.move_speed}, 16'hff00);
    cmd(5, 1'b0);
    cut_n = 0;
    cmd(8, 1'b1);
    settle(6);
    check(cut_n, 1);
    check(ctrl.cut_len, 32'h1000);
    cmd(8, 1'b0);
    clr_n = 0;
    cmd(7, 1'b1);
    settle(6);
    check(clr_n, 1);
    cmd(7, 1'b0);
    $display("test homing jog and pulses done");
    cmd(2, 1'b1);
    settle(2);
    check({ctrl.master_virtual, ctrl.line_enc_en}, 2'b10);
    cmd(3, 1'b1);
    settle(3);
    check((ctrl.vm_freq > 16'h0) && (ctrl.vm_freq < 16'h10), 1'b1);
    settle(10);
    check(ctrl.vm_freq, 16'h10);
    cmd(3, 1'b0);
    settle(3);
    check((ctrl.vm_freq > 16'h0) && (ctrl.vm_freq < 16'h10), 1'b1);
    settle(20);
    check(ctrl.vm_freq, 16'h0);
    cmd(1, 1'b1);
    cmd(2, 1'b0);
    settle(2);
    check({ctrl.auto_cut, ctrl.master_virtual}, 2'b11);
    cmd(4, 1'b1);
    settle(2);
    check({16'h0, ctrl.trim_speed}, 16'h0040);
    cmd(4, 1'b0);
    settle(2);
    check({16'h0, ctrl.trim_speed}, 16'h0);
    cmd(9, 1'b1);
    settle(40);
    check({ctrl.len_trial, ctrl.cut_len}, {1'b1, 32'h200});
    cmd(9, 1'b0);
    cmd(9, 1'b1);
    cmd(9, 1'b0);
    settle(1);
    check(ctrl.cut_len, 32'h200);
    n = 0;
    while (ctrl.len_trial !== 1'b0 && n < 40) begin
      settle(1);
      n = n + 1;
    end
    settle(20);
    check({ctrl.len_trial, ctrl.cut_len}, {1'b0, 32'h1000});
    cmd(1, 1'b0);
    settle(2);
    check({ctrl.master_virtual, ctrl.line_enc_en, ctrl.hold_pos}, 3'b011);
    cmd(0, 1'b0);
    settle(2);
    check({ctrl.enable, ctrl.analog_zero}, 2'b01);
    $display("test master ramp trim and trial done");
    end_sim;
  end
endmodule
